// ### jtap_cfg.svh
`ifndef JTAP_CFG_SVH
`define JTAP_CFG_SVH

// ****************************************
// Instruction codes
// ****************************************
`define JTAP_IR_W          3
`define JTAP_IR_EXTEST     3'h0
`define JTAP_IR_IDREAD     3'h1
`define JTAP_IR_SAMPLE_Z   3'h2
`define JTAP_IR_BYPASS_A   3'h3
`define JTAP_IR_SAMPLE     3'h4
`define JTAP_IR_RESERVED   3'h5
`define JTAP_IR_BYPASS_B   3'h6
`define JTAP_IR_BYPASS_C   3'h7
// Capture value of the instruction register
`define JTAP_IR_CAPTURE    3'h1
// Instruction loaded on reset
`define JTAP_IR_RESET      3'h1

// ****************************************
// Register sizes
// ****************************************
`define JTAP_ID_W          32
`define JTAP_BSR_W         107
// Identity value, arbitrary, bit 0 forced to one
`define JTAP_ID_VALUE      32'h0ABC_DEF1

// ****************************************
// Timing
// ****************************************
`define JTAP_CLK_NS        40
`define JTAP_POR_NS        200
`define JTAP_POR_CYC       ((`JTAP_POR_NS + `JTAP_CLK_NS - 1) / `JTAP_CLK_NS)

`endif

// ### jtap_pkg.sv
`default_nettype none

package jtap_pkg;

    typedef enum logic [3:0]
    {
        JTAP_RESET      = 4'h0,
        JTAP_IDLE       = 4'h1,
        JTAP_SEL_DR     = 4'h2,
        JTAP_CAP_DR     = 4'h3,
        JTAP_SHIFT_DR   = 4'h4,
        JTAP_EXIT1_DR   = 4'h5,
        JTAP_PAUSE_DR   = 4'h6,
        JTAP_EXIT2_DR   = 4'h7,
        JTAP_UPD_DR     = 4'h8,
        JTAP_SEL_IR     = 4'h9,
        JTAP_CAP_IR     = 4'hA,
        JTAP_SHIFT_IR   = 4'hB,
        JTAP_EXIT1_IR   = 4'hC,
        JTAP_PAUSE_IR   = 4'hD,
        JTAP_EXIT2_IR   = 4'hE,
        JTAP_UPD_IR     = 4'hF
    } jtap_state_e;

    // Test pins after synchronisation
    typedef struct packed
    {
        logic tck;
        logic tms;
        logic tdi;
    } jtap_pins_s;

endpackage

`default_nettype wire

// ### jtap_fsm.sv
`timescale 1ns/100ps
`default_nettype none
`include "jtap_cfg.svh"

// ****************************************
// Sixteen-state port sequencer
// ****************************************
module jtap_fsm
(
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    // Advance strobe and mode select
    input  wire logic                 step,
    input  wire logic                 tms,
    // State
    output jtap_pkg::jtap_state_e     state
);
    import jtap_pkg::*;

    jtap_state_e state_nxt;

    always_comb
    begin
        case (state)
            JTAP_RESET:    state_nxt = tms ? JTAP_RESET   : JTAP_IDLE;
            JTAP_IDLE:     state_nxt = tms ? JTAP_SEL_DR  : JTAP_IDLE;
            JTAP_SEL_DR:   state_nxt = tms ? JTAP_SEL_IR  : JTAP_CAP_DR;
            JTAP_CAP_DR:   state_nxt = tms ? JTAP_EXIT1_DR : JTAP_SHIFT_DR;
            JTAP_SHIFT_DR: state_nxt = tms ? JTAP_EXIT1_DR : JTAP_SHIFT_DR;
            JTAP_EXIT1_DR: state_nxt = tms ? JTAP_UPD_DR  : JTAP_PAUSE_DR;
            JTAP_PAUSE_DR: state_nxt = tms ? JTAP_EXIT2_DR : JTAP_PAUSE_DR;
            JTAP_EXIT2_DR: state_nxt = tms ? JTAP_UPD_DR  : JTAP_SHIFT_DR;
            JTAP_UPD_DR:   state_nxt = tms ? JTAP_SEL_DR  : JTAP_IDLE;
            JTAP_SEL_IR:   state_nxt = tms ? JTAP_RESET   : JTAP_CAP_IR;
            JTAP_CAP_IR:   state_nxt = tms ? JTAP_EXIT1_IR : JTAP_SHIFT_IR;
            JTAP_SHIFT_IR: state_nxt = tms ? JTAP_EXIT1_IR : JTAP_SHIFT_IR;
            JTAP_EXIT1_IR: state_nxt = tms ? JTAP_UPD_IR  : JTAP_PAUSE_IR;
            JTAP_PAUSE_IR: state_nxt = tms ? JTAP_EXIT2_IR : JTAP_PAUSE_IR;
            JTAP_EXIT2_IR: state_nxt = tms ? JTAP_UPD_IR  : JTAP_SHIFT_IR;
            JTAP_UPD_IR:   state_nxt = tms ? JTAP_SEL_DR  : JTAP_IDLE;
            default:       state_nxt = JTAP_RESET;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= JTAP_RESET;
        else if (step)
            state <= state_nxt;
    end

endmodule // jtap_fsm

`default_nettype wire

// ### jtap_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "jtap_cfg.svh"

// Summary of operation
// - Port with sequencer, instruction, bypass, identity
// - Standard sixteen states, TMS on TCK rise
// - Self reset at power-up, no reset pin
// - Test mode captures package pad levels
// - Memory contents never reach scan path
// - Idle port leaves memory operation untouched
// - Floating TMS or TDI must arrive as one; no internal pull-up
// - Three-bit instruction, codes as listed
// - EXTEST and SAMPLE-Z float data pins
// - Bypass cleared on select, holds TDI
// - 32-bit identity, bit0 one, TDI-fed
module jtap_port
#(
    parameter int PAD_W = `JTAP_BSR_W
)
(
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    // Test pins; floating pins must arrive as one
    input  wire logic                 tck,
    input  wire logic                 tms,
    input  wire logic                 tdi,
    output logic                      tdo,
    output logic                      tdo_oe,
    // Package pad levels and boundary update
    input  wire logic [PAD_W-1:0]     pad_in,
    output logic [PAD_W-1:0]          pad_out,
    // Data pin float request to the memory core
    output logic                      data_float,
    // Debug view
    output logic [`JTAP_IR_W-1:0]     instr
);
    import jtap_pkg::*;

    // ****************************************
    // Reset release and synchronisers
    // ****************************************
    logic [1:0]                  rst_sync_r;
    logic                        rst_n_i;
    logic [2:0]                  meta_r;
    logic [PAD_W-1:0]            pad_meta_r;
    logic [PAD_W-1:0]            pad_sync_r;
    jtap_pins_s                  pins_r;
    logic                        tck_d_r;
    logic                        rise;
    logic                        fall;
    logic [$clog2(`JTAP_POR_CYC+1)-1:0] por_r;
    logic                        por_done;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n_i = rst_sync_r[1];

    // Power-up hold of the sequencer in its reset state
    always_ff @(posedge ref_clk or negedge rst_n_i)
    begin
        if (!rst_n_i)
            por_r <= '0;
        else if (!por_done)
            por_r <= por_r + 1'b1;
    end
    assign por_done = (por_r == ($bits(por_r))'(`JTAP_POR_CYC));

    // Two stages before any logic looks at the pins
    always_ff @(posedge ref_clk or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_r  <= 3'h3;
            pins_r  <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
            tck_d_r <= 1'b0;
        end
        else
        begin
            meta_r  <= {tck, tms, tdi};
            pins_r  <= meta_r;
            tck_d_r <= pins_r.tck;
        end
    end

    // Pad levels arrive from the pins; each bit settles on its own
    always_ff @(posedge ref_clk or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pad_meta_r <= '0;
            pad_sync_r <= '0;
        end
        else
        begin
            pad_meta_r <= pad_in;
            pad_sync_r <= pad_meta_r;
        end
    end

    // A tied-low TCK never makes an edge, so nothing moves
    assign rise = pins_r.tck & ~tck_d_r & por_done;
    assign fall = ~pins_r.tck & tck_d_r;

    // ****************************************
    // Sequencer
    // ****************************************
    jtap_state_e state;

    jtap_fsm u_fsm
    (
        .ref_clk (ref_clk),
        .rst_n   (rst_n_i),
        .step    (rise),
        .tms     (pins_r.tms),
        .state   (state)
    );

    // ****************************************
    // Instruction register
    // ****************************************
    logic [`JTAP_IR_W-1:0] ir_sh_r;
    logic [`JTAP_IR_W-1:0] instr_r;

    always_ff @(posedge ref_clk or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ir_sh_r <= `JTAP_IR_CAPTURE;
            instr_r <= `JTAP_IR_RESET;
        end
        else if (rise)
        begin
            case (state)
                JTAP_RESET:    instr_r <= `JTAP_IR_RESET;
                JTAP_CAP_IR:   ir_sh_r <= `JTAP_IR_CAPTURE;
                JTAP_SHIFT_IR: ir_sh_r <= {pins_r.tdi, ir_sh_r[`JTAP_IR_W-1:1]};
                JTAP_UPD_IR:   instr_r <= ir_sh_r;
                default:       ;
            endcase
        end
    end

    function automatic logic is_bsr(input logic [`JTAP_IR_W-1:0] c);
        is_bsr = (c == `JTAP_IR_EXTEST) || (c == `JTAP_IR_SAMPLE_Z)
              || (c == `JTAP_IR_SAMPLE);
    endfunction

    // ****************************************
    // Data registers
    // ****************************************
    logic                  byp_r;
    logic [`JTAP_ID_W-1:0] id_r;
    logic [PAD_W-1:0]      bsr_r;

    always_ff @(posedge ref_clk or negedge rst_n_i)
    begin
        if (!rst_n_i)
            byp_r <= 1'b0;
        else if (rise && state == JTAP_UPD_IR)
            byp_r <= 1'b0;
        else if (rise && state == JTAP_CAP_DR)
            byp_r <= 1'b0;
        else if (rise && state == JTAP_SHIFT_DR)
            byp_r <= pins_r.tdi;
    end

    always_ff @(posedge ref_clk or negedge rst_n_i)
    begin
        if (!rst_n_i)
            id_r <= `JTAP_ID_VALUE | 32'h1;
        else if (rise && state == JTAP_CAP_DR)
            id_r <= `JTAP_ID_VALUE | 32'h1;
        else if (rise && state == JTAP_SHIFT_DR && instr_r == `JTAP_IR_IDREAD)
            id_r <= {pins_r.tdi, id_r[`JTAP_ID_W-1:1]};
    end

    // Only pad levels are captured; the array has no path here
    always_ff @(posedge ref_clk or negedge rst_n_i)
    begin
        if (!rst_n_i)
            bsr_r <= '0;
        else if (rise && state == JTAP_CAP_DR && is_bsr(instr_r))
            bsr_r <= pad_sync_r;
        else if (rise && state == JTAP_SHIFT_DR && is_bsr(instr_r))
            bsr_r <= {pins_r.tdi, bsr_r[PAD_W-1:1]};
    end

    always_ff @(posedge ref_clk or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pad_out <= '0;
        else if (rise && state == JTAP_UPD_DR && instr_r == `JTAP_IR_EXTEST)
            pad_out <= bsr_r;
    end

    // Float follows the active instruction; reset leaves pins driven
    always_ff @(posedge ref_clk or negedge rst_n_i)
    begin
        if (!rst_n_i)
            data_float <= 1'b0;
        else
            data_float <= (instr_r == `JTAP_IR_EXTEST)
                       || (instr_r == `JTAP_IR_SAMPLE_Z);
    end

    // ****************************************
    // Serial output, changed on TCK fall
    // ****************************************
    logic tdo_sel;

    always_comb
    begin
        if (state == JTAP_SHIFT_IR)
            tdo_sel = ir_sh_r[0];
        else if (instr_r == `JTAP_IR_IDREAD)
            tdo_sel = id_r[0];
        else if (is_bsr(instr_r))
            tdo_sel = bsr_r[0];
        else
            tdo_sel = byp_r;
    end

    always_ff @(posedge ref_clk or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else if (fall)
        begin
            tdo    <= tdo_sel;
            tdo_oe <= (state == JTAP_SHIFT_IR) || (state == JTAP_SHIFT_DR);
        end
    end

    assign instr = instr_r;

    // ****************************************
    // Checks
    // ****************************************
    a_float_follow: assert property (@(posedge ref_clk) disable iff (!rst_n_i)
        (instr_r == `JTAP_IR_SAMPLE) |=> !data_float)
        else $error("Sample must not float data pins");
    a_tdo_on_fall: assert property (@(posedge ref_clk) disable iff (!rst_n_i)
        !fall |=> $stable(tdo))
        else $error("TDO changed without a TCK fall");
    a_reset_hold: assert property (@(posedge ref_clk) disable iff (!rst_n_i)
        !por_done |=> state == JTAP_RESET)
        else $error("Sequencer left reset during power-up");
    a_idle_stop: assert property (@(posedge ref_clk) disable iff (!rst_n_i)
        !rise |=> $stable(state))
        else $error("State moved without a TCK rise");
    a_id_start: assert property (@(posedge ref_clk) disable iff (!rst_n_i)
        (rise && state == JTAP_CAP_DR) |=> id_r[0])
        else $error("Identity bit 0 not one");
    a_byp_clear: assert property (@(posedge ref_clk) disable iff (!rst_n_i)
        (rise && state == JTAP_UPD_IR) |=> !byp_r)
        else $error("Bypass not cleared on instruction load");
    a_byp_load: assert property (@(posedge ref_clk) disable iff (!rst_n_i)
        (rise && state == JTAP_SHIFT_DR) |=> byp_r == $past(pins_r.tdi))
        else $error("Bypass did not take TDI");
    a_tms_reset: assert property (@(posedge ref_clk) disable iff (!rst_n_i)
        (rise && pins_r.tms && state == JTAP_SEL_IR) |=> state == JTAP_RESET)
        else $error("Select-IR with TMS high must reach reset");
    a_ir_update: assert property (@(posedge ref_clk) disable iff (!rst_n_i)
        (rise && state == JTAP_UPD_IR) |=> instr_r == $past(ir_sh_r))
        else $error("Instruction not updated");
    a_tdo_enable: assert property (@(posedge ref_clk) disable iff (!rst_n_i)
        (fall && (state == JTAP_SHIFT_IR || state == JTAP_SHIFT_DR)) |=> tdo_oe)
        else $error("TDO not enabled while shifting");

endmodule // jtap_port

`default_nettype wire

// ### jtap_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Boundary-scan controller model
// ****************************************
module jtap_host_model
(
    // System clock, paces the test clock
    input  wire logic ref_clk,
    // Test pins
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    // Half of the 320 ns test clock in system cycles
    localparam int HALF = 4;

    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // Tdo is taken just before the rise, a full half period after the fall
    task automatic pulse(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        @(negedge ref_clk);
        q = tdo;
        tck = 1'b1;
        repeat (HALF) @(negedge ref_clk);
        tck = 1'b0;
        repeat (HALF - 1) @(negedge ref_clk);
    endtask

    task automatic reset_port();
        logic q;
        repeat (5) pulse(1'b1, 1'b1, q);
        pulse(1'b0, 1'b1, q);
    endtask

    // Idle to capture, shift n bits bit 0 first, update, back to idle
    task automatic scan(input bit ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic q;
        dout = '0;
        pulse(1'b1, 1'b1, q);
        if (ir)
            pulse(1'b1, 1'b1, q);
        pulse(1'b0, 1'b1, q);
        pulse(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++)
        begin
            pulse(i == n - 1, din[i], q);
            dout[i] = q;
        end
        pulse(1'b1, 1'b1, q);
        pulse(1'b0, 1'b1, q);
    endtask

    // Mode and data pins toggle while the test clock stays low
    task automatic wiggle(input int n);
        repeat (n)
        begin
            @(negedge ref_clk);
            tms = ~tms;
            tdi = ~tdi;
        end
        @(negedge ref_clk);
        tms = 1'b1;
        tdi = 1'b1;
        @(negedge ref_clk);
    endtask
endmodule // jtap_host_model

`default_nettype wire

// ### testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "jtap_cfg.svh"

// ****************************************
// Self-checking bench
// ****************************************
module testbench;
    localparam int PAD_W = `JTAP_BSR_W;
    localparam int LIMIT = 30000;

    logic             ref_clk;
    logic             reset_n;
    logic             tck;
    logic             tms;
    logic             tdi;
    logic             tdo;
    logic             tdo_oe;
    logic [PAD_W-1:0] pad_in;
    logic [PAD_W-1:0] pad_out;
    logic             data_float;
    logic [2:0]       instr;
    int               n_mismatch = 0;
    int               checked = 0;
    int               cycles = 0;

    jtap_port #(.PAD_W(PAD_W)) u_dut
    (
        .ref_clk    (ref_clk),
        .reset_n    (reset_n),
        .tck        (tck),
        .tms        (tms),
        .tdi        (tdi),
        .tdo        (tdo),
        .tdo_oe     (tdo_oe),
        .pad_in     (pad_in),
        .pad_out    (pad_out),
        .data_float (data_float),
        .instr      (instr)
    );

    jtap_host_model u_host
    (
        .ref_clk (ref_clk),
        .tck     (tck),
        .tms     (tms),
        .tdi     (tdi),
        .tdo     (tdo)
    );

    always #20 ref_clk = ~ref_clk;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Run-away guard, well above the few thousand cycles needed
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            n_mismatch++;
            $display("mismatch at %0t: run timed out", $time);
            print_verdict();
        end
    end

    task automatic check(input logic [127:0] got, input logic [127:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask

    task automatic load_ir(input logic [2:0] code);
        logic [127:0] q;
        u_host.scan(1'b1, 3, {125'h0, code}, q);
        check(q[2:0], `JTAP_IR_CAPTURE, "instruction capture");
        check(tdo_oe, 1'b0, "tdo released in idle");
    endtask

    task automatic test_reset();
        check(instr, `JTAP_IR_RESET, "reset instruction");
        check({tdo, tdo_oe, data_float}, 3'h0, "reset outputs");
        check(pad_out, '0, "reset pads");
        $display("test reset done");
    endtask

    task automatic test_idcode();
        logic [127:0] q;
        u_host.reset_port();
        u_host.scan(1'b0, 64, 128'h3C5A_A5C3, q);
        check(q[31:0], `JTAP_ID_VALUE, "identity");
        check(q[0], 1'b1, "identity start bit");
        check(q[63:32], 32'h3C5A_A5C3, "identity passes tdi");
        $display("test idcode done");
    endtask

    task automatic test_instr();
        for (int c = 0; c < 8; c++)
        begin
            load_ir(c[2:0]);
            if (c != 5)
                check(instr, c[2:0], "instruction");
            check(data_float, c == 0 || c == 2, "data float");
        end
        $display("test instr done");
    endtask

    // Bypass left holding a one must start from zero on the next code
    task automatic test_bypass();
        logic [2:0]   codes [4] = '{3'h3, 3'h6, 3'h7, 3'h5};
        logic [127:0] q;
        foreach (codes[i])
        begin
            load_ir(codes[i]);
            u_host.scan(1'b0, 8, 128'hB5, q);
            check(q[7:0], 8'h6A, "bypass path");
        end
        $display("test bypass done");
    endtask

    task automatic test_pads();
        logic [2:0]   codes [3] = '{3'h4, 3'h2, 3'h0};
        logic [127:0] q;
        foreach (codes[i])
        begin
            load_ir(codes[i]);
            check(data_float, codes[i] != 3'h4, "float on sample");
            u_host.scan(1'b0, PAD_W, {21'h0, ~pad_in}, q);
            check(q[PAD_W-1:0], pad_in, "pad capture");
            if (codes[i] == 3'h0)
                check(pad_out, {21'h0, ~pad_in}, "pad update");
        end
        $display("test pads done");
    endtask

    task automatic test_idle();
        load_ir(3'h7);
        u_host.wiggle(40);
        check({instr, data_float}, {3'h7, 1'b0}, "idle port steady");
        u_host.reset_port();
        check(instr, `JTAP_IR_RESET, "reset by mode pin");
        $display("test idle done");
    endtask

    initial
    begin
        ref_clk = 1'b0;
        reset_n = 1'b0;
        pad_in  = {11'h5A3, 32'hDEAD_BEEF, 64'h0123_4567_89AB_CDEF};
        repeat (16) @(negedge ref_clk);
        test_reset();
        reset_n = 1'b1;
        // Let the internal power-up hold run out
        repeat (12) @(negedge ref_clk);
        test_idcode();
        test_instr();
        test_bypass();
        test_pads();
        test_idle();
        print_verdict();
    end
endmodule // testbench

`default_nettype wire
